// file: test/ssf_peer.sv
// ssf_peer: far-side serial peer driving the link clock and frame sync
// assumes: the bench calls its tasks; lines idle low outside frames
`timescale 1ns/1ps

// ----------------------------------------
// serial peer model
// ----------------------------------------
module ssf_peer (
   output logic sck_o,   // serial clock, still between frames
   output logic fsync_o  // frame sync, idles low
);
   // idle levels from time zero
   initial begin
      sck_o = 1'b0;
      fsync_o = 1'b0;
   end

   // n link clock periods of 80 ns, odd offset keeps phase unrelated
   task automatic clocks(input int n);
      #3;
      repeat (n) begin
         #40;
         sck_o = 1'b1;
         #40;
         sck_o = 1'b0;
      end
   endtask

   // one frame sync pulse, one link period wide
   task automatic frame_pulse();
      #40;
      fsync_o = 1'b1;
      #80;
      fsync_o = 1'b0;
   endtask
endmodule

// file: test/tb_spi_status_flags.sv
// tb_spi_status_flags: apb-driven checks of the serial status block
// assumes: ssf_pkg compiled first, ssf_defs.svh on the include path
`timescale 1ns/1ps
`include "ssf_defs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
   $display("Error t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_spi_status_flags;
   // ----------------------------------------
   // event codes, rx_word down to tx_load
   // ----------------------------------------
   localparam ssf_pkg::ssf_ev_t RXW = 4'h8; // shifter finished a word
   localparam ssf_pkg::ssf_ev_t RXR = 4'h4; // software read data
   localparam ssf_pkg::ssf_ev_t TXW = 4'h2; // software wrote data
   localparam ssf_pkg::ssf_ev_t TXL = 4'h1; // shifter takes a word

   logic             clk_i;     // module clock
   logic             rstn_i;    // async reset, low
   logic             psel;      // apb select
   logic             penable;   // apb access phase
   logic             pwrite;    // apb direction
   logic [11:0]      paddr;     // apb address
   logic [31:0]      pwdata;    // apb write data
   logic [31:0]      prdata;    // apb read data
   logic             pready;    // apb ready
   logic             pslverr;   // apb error
   logic             irq;       // level interrupt
   logic             sck;       // link clock from peer
   logic             fsync;     // frame sync from peer
   ssf_pkg::ssf_ev_t ev;        // shifter and software events
   logic [31:0]      rd;        // last read word
   logic             err;       // last error response
   int               fails;     // mismatch count
   int               cmp_count; // comparison count
   int               cyc;       // cycles run

   // ----------------------------------------
   // design, peer and clock
   // ----------------------------------------
   ssf_status uut (
      .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .ev_i(ev), .sck_i(sck),
      .fsync_i(fsync), .irq_o(irq)
   );
   ssf_peer peer (.sck_o(sck), .fsync_o(fsync));

   // 125 MHz clock
   initial clk_i = 1'b0;
   always #4 clk_i = ~clk_i;

   // hang guard, tests need well under 2000 cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         wrap_up();
      end
   end

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   // verdict and end of run
   task automatic wrap_up();
      if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // one apb transfer, held until ready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      // edge value, read before the design's update lands
      do @(posedge clk_i); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // read and compare
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(rd, exp)
   endtask

   // event held high for n cycles, one event per cycle
   task automatic pulse(input ssf_pkg::ssf_ev_t e, input int n);
      @(posedge clk_i);
      ev <= e;
      repeat (n) @(posedge clk_i);
      ev <= 4'h0;
   endtask

   // let registered outputs and pin synchronisers land
   task automatic settle();
      repeat (4) @(negedge clk_i);
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rstn_i = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      ev = 4'h0;
      fails = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      rchk(`SSF_OFF_STAT, 32'h0000_00A8);
      rchk(`SSF_OFF_CTRL, 32'h0000_0000);
      apb(1'b0, 12'h010, 32'h0000_0000);
      `CHK({err, rd}, {1'b1, 32'h0000_0000})
      pulse(TXW, 1);
      rchk(`SSF_OFF_STAT, 32'h0000_00A8);
      apb(1'b1, `SSF_OFF_CTRL, 32'h0000_0007);
      pulse(TXW, 17);
      rchk(`SSF_OFF_STAT, 32'h0010_00A2);
      pulse(TXL, 17);
      rchk(`SSF_OFF_STAT, 32'h0000_0928);
      pulse(RXW, 17);
      rchk(`SSF_OFF_STAT, 32'h1000_01C9);
      // interrupt status, mask, clear
      rchk(`SSF_OFF_IRQST, 32'h0000_0003);
      `CHK(irq, 1'b0)
      apb(1'b1, `SSF_OFF_IRQMSK, 32'h0000_0001);
      settle();
      `CHK(irq, 1'b1)
      apb(1'b1, `SSF_OFF_IRQST, 32'h0000_0001);
      settle();
      `CHK(irq, 1'b0)
      rchk(`SSF_OFF_IRQST, 32'h0000_0002);
      apb(1'b1, `SSF_OFF_STAT, 32'hFFFF_FFFF);
      rchk(`SSF_OFF_STAT, 32'h1000_01C9);
      apb(1'b1, `SSF_OFF_STAT, 32'h0000_0000);
      rchk(`SSF_OFF_STAT, 32'h1000_0089);
      pulse(RXW, 1);
      pulse(TXL, 1);
      pulse(RXR, 16);
      rchk(`SSF_OFF_STAT, 32'h0000_01E8);
      apb(1'b1, `SSF_OFF_CTRL, 32'h0000_0000);
      apb(1'b1, `SSF_OFF_CTRL, 32'h0000_0007);
      rchk(`SSF_OFF_STAT, 32'h0000_00A8);
      apb(1'b1, `SSF_OFF_IRQST, 32'h0000_0007);
      apb(1'b1, `SSF_OFF_IRQMSK, 32'h0000_0004);
      peer.clocks(3);
      settle();
      rchk(`SSF_OFF_STAT, 32'h0000_08A8);
      peer.frame_pulse();
      settle();
      rchk(`SSF_OFF_STAT, 32'h0000_18A8);
      `CHK(irq, 1'b1)
      apb(1'b1, `SSF_OFF_STAT, 32'h0000_0000);
      rchk(`SSF_OFF_STAT, 32'h0000_08A8);
      pulse(RXW, 1);
      rchk(`SSF_OFF_STAT, 32'h0100_0088);
      apb(1'b1, `SSF_OFF_CTRL, 32'h0000_0000);
      apb(1'b1, `SSF_OFF_CTRL, 32'h0000_0003);
      peer.clocks(2);
      peer.frame_pulse();
      settle();
      pulse(TXL, 1);
      rchk(`SSF_OFF_STAT, 32'h0000_08A8);
      wrap_up();
   end
endmodule

// file: verilog/ssf_defs.svh
// ssf_defs.svh: offsets, field positions, reset values and sizes
// assumes: included by bare name from the status block and bench
`ifndef SSF_DEFS_SVH
`define SSF_DEFS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SSF_OFF_STAT   12'h000
`define SSF_OFF_CTRL   12'h004
`define SSF_OFF_IRQST  12'h008
`define SSF_OFF_IRQMSK 12'h00C
// ----------------------------------------
// status word field positions
// ----------------------------------------
`define SSF_BIT_FERR   12
`define SSF_BIT_TUR    8
`define SSF_BIT_ROV    6
// ----------------------------------------
// control word field positions
// ----------------------------------------
`define SSF_BIT_ON     0
`define SSF_BIT_ENH    1
`define SSF_BIT_FRM    2
// ----------------------------------------
// interrupt word field positions
// ----------------------------------------
`define SSF_IRQ_ROV    0
`define SSF_IRQ_TUR    1
`define SSF_IRQ_FERR   2
`define SSF_IRQ_W      3
// ----------------------------------------
// sizes and reset values
// ----------------------------------------
`define SSF_DEPTH      5'h10
`define SSF_DEPTH1     5'h01
`define SSF_CTRL_RST   3'h0
`define SSF_MASK_RST   3'h0
`endif

// file: verilog/ssf_pkg.sv
// ssf_pkg: types shared by the status block and its bench
// assumes: field layout matches ssf_defs.svh
package ssf_pkg;
   // ----------------------------------------
   // status word, bit 31 first
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] rsv31;            // reads zero
      logic [4:0] rx_element_count; // 28:24
      logic [2:0] rsv23;            // reads zero
      logic [4:0] tx_element_count; // 20:16
      logic [2:0] rsv15;            // reads zero
      logic       frame_error_flag; // 12
      logic       activity_flag;    // 11
      logic [1:0] rsv10;            // reads zero
      logic       tx_underrun_flag; // 8
      logic       shifter_empty_flag;   // 7
      logic       rx_overflow_flag;     // 6
      logic       rx_fifo_empty_flag;   // 5
      logic       rsv4;                 // reads zero
      logic       tx_buffer_empty_flag; // 3
      logic       rsv2;                 // reads zero
      logic       tx_buffer_full_flag;  // 1
      logic       rx_buffer_full_flag;  // 0
   } ssf_stat_t;
   // ----------------------------------------
   // same-clock events from the shifter and from software
   // ----------------------------------------
   typedef struct packed {
      logic rx_word;  // shifter finished a word
      logic rx_read;  // software read the data buffer
      logic tx_write; // software wrote the data buffer
      logic tx_load;  // shifter wants the next word
   } ssf_ev_t;
endpackage

// file: verilog/ssf_status.sv
// ssf_status: status flags, counts, apb slave and irq of a serial port
// assumes: events arrive on clk_i; sck and frame pins are asynchronous
`timescale 1ns/1ps
`include "ssf_defs.svh"

// Functional notes
// - rx element count at bits 28:24
// - tx element count at bits 20:16
// - frame error flag bit 12, framed
// - activity flag bit 11 while busy
// - tx underrun bit 8, framed mode
// - underrun clears by off/on or zero-write
// - shifter empty flag at bit 7
// - rx overflow bit 6 on discarded word
// - overflow clears by off/on or zero-write
// - rx empty when pointers equal
// - unused status bits read zero
module ssf_status (
   input  wire logic           clk_i,    // 125 MHz module clock
   input  wire logic           rstn_i,   // async reset, active low
   input  wire logic           psel_i,   // apb select
   input  wire logic           penable_i,// apb access phase
   input  wire logic           pwrite_i, // apb direction
   input  wire logic [11:0]    paddr_i,  // apb byte address
   input  wire logic [31:0]    pwdata_i, // apb write data
   output logic      [31:0]    prdata_o, // apb read data
   output logic                pready_o, // apb ready
   output logic                pslverr_o,// apb error, unmapped
   input  wire ssf_pkg::ssf_ev_t ev_i,   // shifter/buffer events
   input  wire logic           sck_i,    // serial clock pin
   input  wire logic           fsync_i,  // frame sync pin
   output logic                irq_o     // level interrupt
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [2:0] ctrl_q;        // on, enhanced, framed
   logic [2:0] msk_q;         // interrupt mask
   logic [2:0] ist_q;         // sticky interrupt status
   logic [4:0] rwp_q;         // fifo_write_pointer, rx
   logic [4:0] rrp_q;         // fifo_read_pointer, rx
   logic [4:0] twp_q;         // tx write pointer
   logic [4:0] trp_q;         // tx read pointer
   logic       ferr_q;        // frame error flag
   logic       tur_q;         // tx underrun flag
   logic       rov_q;         // rx overflow flag
   logic       shf_q;         // shifter holds a word
   logic [4:0] bit_cnt_q;     // sck rising edges in this word
   logic [1:0] s1_q;          // pin sync stage one
   logic [1:0] s2_q;          // pin sync stage two
   logic [1:0] s3_q;          // delayed for edges
   logic       on;            // module enabled
   logic       enh;           // enhanced buffer mode
   logic       frm;           // framed mode
   logic [4:0] depth;         // buffer depth in this mode
   logic [4:0] rcnt;          // rx occupancy
   logic [4:0] tcnt;          // tx occupancy
   logic       rfull;         // rx buffer full
   logic       tfull;         // tx buffer full
   logic       rpush;         // rx word accepted
   logic       rpop;          // rx word read
   logic       tpush;         // tx word accepted
   logic       tpop;          // tx word taken
   logic       ov_ev;         // overflow event
   logic       ur_ev;         // underrun event
   logic       fe_ev;         // frame error event
   logic       sck_rise;      // serial clock rising edge
   logic       fs_rise;       // frame sync rising edge
   logic       acc;           // apb access this cycle
   logic       wr;            // apb write takes effect
   logic       wr_stat;       // status word written
   logic [31:0] rd_data;      // selected read word
   logic       rd_err;        // unmapped address
   ssf_pkg::ssf_stat_t stat;  // assembled status word

   // ----------------------------------------
   // mode and occupancy decode
   // ----------------------------------------
   assign on    = ctrl_q[`SSF_BIT_ON];
   assign enh   = ctrl_q[`SSF_BIT_ENH];
   assign frm   = ctrl_q[`SSF_BIT_FRM];
   assign depth = enh ? `SSF_DEPTH : `SSF_DEPTH1;
   assign rcnt  = rwp_q - rrp_q;
   assign tcnt  = twp_q - trp_q;
   assign rfull = (rcnt == depth);
   assign tfull = (tcnt == depth);
   // discard the new word when the buffer is full
   assign rpush = on & ev_i.rx_word & ~rfull;
   assign rpop  = on & ev_i.rx_read & (rrp_q != rwp_q);
   assign tpush = on & ev_i.tx_write & ~tfull;
   assign tpop  = on & ev_i.tx_load & (trp_q != twp_q);
   assign ov_ev = on & ev_i.rx_word & rfull;
   assign ur_ev = on & frm & ev_i.tx_load & (trp_q == twp_q);
   assign fe_ev = on & frm & fs_rise & (bit_cnt_q != 5'h00);
   assign sck_rise = s2_q[0] & ~s3_q[0];
   assign fs_rise  = s2_q[1] & ~s3_q[1];

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   assign acc     = psel_i & penable_i & ~pready_o;
   assign wr      = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
   assign wr_stat = wr & (paddr_i == `SSF_OFF_STAT);

   // ----------------------------------------
   // status word assembly
   // ----------------------------------------
   always_comb begin
      stat = '0;
      stat.rx_element_count = rcnt;
      stat.tx_element_count = tcnt;
      stat.frame_error_flag = ferr_q;
      stat.activity_flag = shf_q | (bit_cnt_q != 5'h00);
      stat.tx_underrun_flag = tur_q;
      stat.shifter_empty_flag = ~shf_q;
      stat.rx_overflow_flag = rov_q;
      stat.rx_fifo_empty_flag = (rrp_q == rwp_q);
      stat.tx_buffer_empty_flag = (trp_q == twp_q);
      stat.tx_buffer_full_flag  = tfull;
      stat.rx_buffer_full_flag  = rfull;
   end

   // read mux; reserved fields stay zero
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      unique case (paddr_i)
         `SSF_OFF_STAT:   rd_data = stat;
         `SSF_OFF_CTRL:   rd_data = {29'h0, ctrl_q};
         `SSF_OFF_IRQST:  rd_data = {29'h0, ist_q};
         `SSF_OFF_IRQMSK: rd_data = {29'h0, msk_q};
         default:         rd_err  = 1'b1;
      endcase
   end

   // ----------------------------------------
   // apb answer, one wait cycle
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end else begin
         pready_o  <= acc;
         pslverr_o <= acc & rd_err;
         // read data latched with ready
         if (acc && !pwrite_i) begin
            prdata_o <= rd_data;
         end
      end
   end

   // ----------------------------------------
   // control and mask registers
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_q <= `SSF_CTRL_RST;
         msk_q  <= `SSF_MASK_RST;
      end else if (wr) begin
         if (paddr_i == `SSF_OFF_CTRL) begin
            ctrl_q <= pwdata_i[2:0];
         end
         if (paddr_i == `SSF_OFF_IRQMSK) begin
            msk_q <= pwdata_i[2:0];
         end
      end
   end

   // ----------------------------------------
   // link pin synchronisers
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s1_q <= 2'h0;
         s2_q <= 2'h0;
         s3_q <= 2'h0;
      end else begin
         s1_q <= {fsync_i, sck_i};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // ----------------------------------------
   // bit counter and shifter occupancy
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bit_cnt_q <= 5'h00;
         shf_q     <= 1'b0;
      end else if (!on) begin
         bit_cnt_q <= 5'h00;
         shf_q     <= 1'b0;
      end else begin
         // word end restarts the count
         if (ev_i.rx_word) begin
            bit_cnt_q <= 5'h00;
         end else if (sck_rise) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
         end
         if (tpop) begin
            shf_q <= 1'b1;
         end else if (ev_i.rx_word) begin
            shf_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // buffer pointers
   // ----------------------------------------
   // reset and off clear pointers
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rwp_q <= 5'h00;
         rrp_q <= 5'h00;
         twp_q <= 5'h00;
         trp_q <= 5'h00;
      end else if (!on) begin
         rwp_q <= 5'h00;
         rrp_q <= 5'h00;
         twp_q <= 5'h00;
         trp_q <= 5'h00;
      end else begin
         rwp_q <= rwp_q + {4'h0, rpush};
         rrp_q <= rrp_q + {4'h0, rpop};
         twp_q <= twp_q + {4'h0, tpush};
         trp_q <= trp_q + {4'h0, tpop};
      end
   end

   // ----------------------------------------
   // sticky error flags, set wins over clear
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ferr_q <= 1'b0;
         tur_q  <= 1'b0;
         rov_q  <= 1'b0;
      end else if (!on) begin
         ferr_q <= 1'b0;
         tur_q  <= 1'b0;
         rov_q  <= 1'b0;
      end else begin
         ferr_q <= fe_ev | (ferr_q & ~(wr_stat & ~pwdata_i[`SSF_BIT_FERR]));
         tur_q  <= ur_ev | (tur_q & ~(wr_stat & ~pwdata_i[`SSF_BIT_TUR]));
         rov_q  <= ov_ev | (rov_q & ~(wr_stat & ~pwdata_i[`SSF_BIT_ROV]));
      end
   end

   // ----------------------------------------
   // interrupt status, mask and output
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ist_q <= 3'h0;
      end else begin
         // event sets, write one clears
         ist_q[`SSF_IRQ_ROV]  <= ov_ev |
            (ist_q[`SSF_IRQ_ROV] & ~(wr & (paddr_i == `SSF_OFF_IRQST) & pwdata_i[`SSF_IRQ_ROV]));
         ist_q[`SSF_IRQ_TUR]  <= ur_ev |
            (ist_q[`SSF_IRQ_TUR] & ~(wr & (paddr_i == `SSF_OFF_IRQST) & pwdata_i[`SSF_IRQ_TUR]));
         ist_q[`SSF_IRQ_FERR] <= fe_ev |
            (ist_q[`SSF_IRQ_FERR] & ~(wr & (paddr_i == `SSF_OFF_IRQST) & pwdata_i[`SSF_IRQ_FERR]));
      end
   end

   // level irq from unmasked sticky bits
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(ist_q & msk_q);
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   rxcnt_bound_a: assert property (
      rcnt <= depth)
      else $error("rx count above depth");

   txcnt_step_a: assert property (
      on && ev_i.tx_write && !tfull && !ev_i.tx_load && ctrl_q == $past(ctrl_q)
      |=> tcnt == $past(tcnt) + 5'h01)
      else $error("tx count did not step");

   ferr_set_a: assert property (
      fe_ev |=> on |-> ferr_q)
      else $error("frame error not set");

   busy_idle_a: assert property (
      !on |=> !stat.activity_flag)
      else $error("busy while off");

   tur_set_a: assert property (
      ur_ev ##1 on |-> tur_q)
      else $error("underrun not set");

   tur_hold_a: assert property (
      tur_q && on && !wr_stat ##1 on |-> tur_q)
      else $error("underrun cleared itself");

   shifter_empty_flag_load_a: assert property (
      tpop && !ev_i.rx_word ##1 on |-> !stat.shifter_empty_flag)
      else $error("shifter empty after load");

   rov_set_a: assert property (
      on && ev_i.rx_word && rfull ##1 on |-> rov_q && rcnt == $past(rcnt) - {4'h0, $past(rpop)})
      else $error("overflow not set or word kept");

   rov_hold_a: assert property (
      rov_q && on && !wr_stat ##1 on |-> rov_q)
      else $error("overflow cleared itself");

   rxe_last_a: assert property (
      on && rcnt == 5'h01 && ev_i.rx_read && !ev_i.rx_word ##1 on |-> stat.rx_fifo_empty_flag)
      else $error("rx not empty after last read");

   rsv_zero_a: assert property (
      pready_o && $past(paddr_i) == `SSF_OFF_STAT && !$past(pwrite_i)
      |-> prdata_o[31:29] == 3'h0 && prdata_o[15:13] == 3'h0 && prdata_o[10:9] == 2'h0)
      else $error("reserved status bits set");

   tx_flags_a: assert property (
      stat.tx_buffer_full_flag |-> !stat.tx_buffer_empty_flag)
      else $error("tx full and empty together");

   off_clear_a: assert property (
      !on ##1 !on |-> !rov_q && !tur_q && !ferr_q && stat.tx_buffer_empty_flag)
      else $error("flags not cleared while off");
endmodule
